// ==== asor_pkg.sv ====
// Constants shared by the axis sample output register bank
// -----------------------------------------------------------------------------
// How it works
// - Each axis sample is held as a 14-bit two's-complement word.
// - The six axis bytes sit at addresses 0x01 to 0x06, X then Y then Z, high byte first.
// - A low byte reads back only directly after its own high byte in one burst; else zero.
// - A high-byte read locks the low byte, so both bytes come from the same sample.
// - The X high byte at 0x01 holds sample bits 13 to 6, resets to zero, read-only.
// - The X low byte at 0x02 holds sample bits 5 to 0, resets to zero, read-only.
// - Y uses 0x03 and 0x04 and Z uses 0x05 and 0x06 in the same way, zero at reset.
// - One count is one milli-g over a range of plus and minus eight g.
// - 0x1FFF is the positive maximum, zero is zero g, all ones is minus one count, 0x2000 is min.
// - Each low byte carries its six sample bits in bit positions 7 to 2.
// - Each axis flag clears on its high-byte read; the all-axes flag after all three are read.
// - All contents clear while enable is low; while enable stays high each sample is kept until the next load.
// -----------------------------------------------------------------------------
package asor_pkg;
   localparam int N_AXES = 3;
   localparam int SAMPLE_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int HI_LSB = 6;
   localparam int LO_W = 6;
   localparam int LO_PAD_W = 2;
   localparam logic [ADDR_W-1:0] ADDR_X_HI = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_X_LO = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_Y_HI = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_Y_LO = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_Z_HI = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_Z_LO = 8'h06;
   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [SAMPLE_W-1:0] RESET_SAMPLE = 14'h0000;
   localparam logic [LO_PAD_W-1:0] LO_PAD = 2'h0;
   localparam logic [SAMPLE_W-1:0] SAMPLE_POS_MAX = 14'h1FFF;
   localparam logic [SAMPLE_W-1:0] SAMPLE_NEG_MAX = 14'h2000;
   localparam int MG_PER_COUNT = 1;
   localparam int FULL_SCALE_G = 8;
   localparam logic [N_AXES-1:0] ALL_AXES = 3'h7;
endpackage

// ==== asor_axis_if.sv ====
// Signals between the register bank top and one axis store
`timescale 1ns/10ps
interface asor_axis_if;
   logic [asor_pkg::SAMPLE_W-1:0] sample_in;
   logic load;
   logic hi_read;
   logic [asor_pkg::SAMPLE_W-1:0] word;
   logic [asor_pkg::DATA_W-1:0] hi_byte;
   logic [asor_pkg::DATA_W-1:0] lo_byte;
   logic ready;
   modport store (
      input sample_in, load, hi_read,
      output word, hi_byte, lo_byte, ready
   );
   modport ctl (
      output sample_in, load, hi_read,
      input word, hi_byte, lo_byte, ready
   );
endinterface

// ==== asor_axis_reg.sv ====
// One axis: sample word, locked low byte and per-axis ready flag
`timescale 1ns/10ps
module asor_axis_reg (
   // Clock and control
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_en,
   // Axis link to the top
   asor_axis_if.store ax
);
   logic [asor_pkg::SAMPLE_W-1:0] sample;
   logic [asor_pkg::LO_W-1:0] locked_lo;
   logic ready;

   // -------------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------------
   // A load in the same cycle as a high read still locks the old low bits,
   // matching the high byte just returned
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sample <= asor_pkg::RESET_SAMPLE;
         locked_lo <= '0;
         ready <= 1'b0;
      end else if (i_ce) begin
         if (!i_en) begin
            sample <= asor_pkg::RESET_SAMPLE;
            locked_lo <= '0;
            ready <= 1'b0;
         end else begin
            if (ax.load) begin
               sample <= ax.sample_in;
            end
            if (ax.hi_read) begin
               locked_lo <= sample[asor_pkg::LO_W-1:0];
            end
            if (ax.load) begin
               ready <= 1'b1;
            end else if (ax.hi_read) begin
               ready <= 1'b0;
            end
         end
      end
   end

   assign ax.word = sample;
   assign ax.hi_byte = sample[asor_pkg::SAMPLE_W-1:asor_pkg::HI_LSB];
   assign ax.lo_byte = {locked_lo, asor_pkg::LO_PAD};
   assign ax.ready = ready;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   property p_axis_lock;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && ax.hi_read) |=> (ax.lo_byte[7:2] == $past(sample[5:0]));
   endproperty
   a_axis_lock: assert property (p_axis_lock) else $error("low byte not locked");

   property p_axis_ready;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && ax.hi_read && !ax.load) |=> !ready;
   endproperty
   a_axis_ready: assert property (p_axis_ready) else $error("axis flag kept");
endmodule

// ==== asor_ready_track.sv ====
// All-axes ready flag: set on a fresh sample, cleared once all high bytes read
`timescale 1ns/10ps
module asor_ready_track (
   // Clock and control
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_en,
   // Events
   input wire logic i_load,
   input wire logic [asor_pkg::N_AXES-1:0] i_hi_read,
   // Flag
   output logic o_all_axes_ready_flag
);
   logic [asor_pkg::N_AXES-1:0] seen;
   logic [asor_pkg::N_AXES-1:0] next_seen;
   logic all_read;

   assign next_seen = seen | i_hi_read;
   assign all_read = (next_seen == asor_pkg::ALL_AXES);

   // A sample arriving with the last high read wins: new data stays flagged
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seen <= '0;
         o_all_axes_ready_flag <= 1'b0;
      end else if (i_ce) begin
         if (!i_en) begin
            seen <= '0;
            o_all_axes_ready_flag <= 1'b0;
         end else if (i_load) begin
            seen <= '0;
            o_all_axes_ready_flag <= 1'b1;
         end else if (o_all_axes_ready_flag) begin
            seen <= all_read ? '0 : next_seen;
            if (all_read) begin
               o_all_axes_ready_flag <= 1'b0;
            end
         end
      end
   end

   property p_all_clear;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_load && o_all_axes_ready_flag && all_read) |=> !o_all_axes_ready_flag;
   endproperty
   a_all_clear: assert property (p_all_clear) else $error("all-axes flag kept");

   property p_all_set;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && i_load) |=> o_all_axes_ready_flag;
   endproperty
   a_all_set: assert property (p_all_set) else $error("all-axes flag not set");
endmodule

// ==== asor_regs.sv ====
// Axis sample output register bank: read port, decode and coherent byte pairs
`timescale 1ns/10ps
module asor_regs (
   // Clock, reset, clock enable
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Enable pin level, synchronous
   input wire logic i_en,
   // New sample from the converter
   input wire logic i_sample_valid,
   input wire logic [asor_pkg::SAMPLE_W-1:0] i_x_sample_bits,
   input wire logic [asor_pkg::SAMPLE_W-1:0] i_y_sample_bits,
   input wire logic [asor_pkg::SAMPLE_W-1:0] i_z_sample_bits,
   // Register read port from the serial engine
   input wire logic i_rd_req,
   input wire logic [asor_pkg::ADDR_W-1:0] i_rd_addr,
   input wire logic i_rd_seq,
   output logic [asor_pkg::DATA_W-1:0] o_rd_data,
   output logic o_rd_ack,
   // Ready flags
   output logic [asor_pkg::N_AXES-1:0] o_axis_ready,
   output logic o_all_axes_ready_flag
);
   // -------------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------------
   logic [asor_pkg::SAMPLE_W-1:0] samples [asor_pkg::N_AXES];
   logic [asor_pkg::DATA_W-1:0] hi_bytes [asor_pkg::N_AXES];
   logic [asor_pkg::DATA_W-1:0] lo_bytes [asor_pkg::N_AXES];
   logic [asor_pkg::SAMPLE_W-1:0] words [asor_pkg::N_AXES];
   logic [asor_pkg::N_AXES-1:0] ready_bits;
   logic [asor_pkg::N_AXES-1:0] hi_read;
   logic rd_take;
   logic in_range;
   logic [asor_pkg::ADDR_W-1:0] addr_off;
   logic [1:0] axis_sel;
   logic hit_hi;
   logic hit_lo;
   logic lo_ok;
   logic [asor_pkg::DATA_W-1:0] rd_byte;
   logic prev_hi;
   logic [1:0] prev_axis;

   assign samples[0] = i_x_sample_bits;
   assign samples[1] = i_y_sample_bits;
   assign samples[2] = i_z_sample_bits;

   assign rd_take = i_rd_req && i_en;
   assign in_range = (i_rd_addr >= asor_pkg::ADDR_X_HI) && (i_rd_addr <= asor_pkg::ADDR_Z_LO);
   assign addr_off = i_rd_addr - asor_pkg::ADDR_X_HI;
   assign axis_sel = addr_off[2:1];
   assign hit_hi = rd_take && in_range && !addr_off[0];
   assign hit_lo = rd_take && in_range && addr_off[0];
   // Random access to a low byte returns zero rather than a stale lock
   assign lo_ok = i_rd_seq && prev_hi && (prev_axis == axis_sel);
   assign rd_byte = hit_hi ? hi_bytes[axis_sel] :
                    (hit_lo && lo_ok) ? lo_bytes[axis_sel] : asor_pkg::RESET_BYTE;

   // -------------------------------------------------------------------------
   // Axis stores
   // -------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < asor_pkg::N_AXES; gi++) begin : g_axis
         asor_axis_if ax_if ();
         assign ax_if.sample_in = samples[gi];
         assign ax_if.load = i_sample_valid;
         assign ax_if.hi_read = hi_read[gi];
         assign hi_read[gi] = hit_hi && (axis_sel == 2'(gi));
         assign hi_bytes[gi] = ax_if.hi_byte;
         assign lo_bytes[gi] = ax_if.lo_byte;
         assign words[gi] = ax_if.word;
         assign ready_bits[gi] = ax_if.ready;
         asor_axis_reg u_axis (
            .i_ref_clk(i_ref_clk),
            .i_rst_n(i_rst_n),
            .i_ce(i_ce),
            .i_en(i_en),
            .ax(ax_if.store)
         );
      end
   endgenerate

   assign o_axis_ready = ready_bits;

   asor_ready_track u_track (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_en(i_en),
      .i_load(i_sample_valid),
      .i_hi_read(hi_read),
      .o_all_axes_ready_flag(o_all_axes_ready_flag)
   );

   // -------------------------------------------------------------------------
   // Read answer and burst history
   // -------------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_data <= asor_pkg::RESET_BYTE;
         o_rd_ack <= 1'b0;
         prev_hi <= 1'b0;
         prev_axis <= 2'h0;
      end else if (i_ce) begin
         o_rd_data <= rd_byte;
         o_rd_ack <= i_rd_req;
         if (i_rd_req) begin
            prev_hi <= hit_hi;
            prev_axis <= axis_sel;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   property p_ack;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_rd_req) |=> o_rd_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("read not answered");

   property p_x_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_X_HI)
         |=> (o_rd_data == $past(words[0][13:6]));
   endproperty
   a_x_hi: assert property (p_x_hi) else $error("x high byte wrong");

   property p_z_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_Z_HI)
         |=> (o_rd_data == $past(words[2][13:6]));
   endproperty
   a_z_hi: assert property (p_z_hi) else $error("z high byte wrong");

   property p_lo_random;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && hit_lo && !i_rd_seq) |=> (o_rd_data == asor_pkg::RESET_BYTE);
   endproperty
   a_lo_random: assert property (p_lo_random) else $error("random low read");

   sequence s_y_pair;
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_Y_HI)
         ##1 (i_ce && rd_take && i_rd_seq && i_rd_addr == asor_pkg::ADDR_Y_LO);
   endsequence

   property p_y_pair;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_y_pair |=> (o_rd_data[7:2] == $past(words[1][5:0], 2)) && (o_rd_data[1:0] == 2'h0);
   endproperty
   a_y_pair: assert property (p_y_pair) else $error("y pair incoherent");

   property p_x_lo;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_X_HI && !i_sample_valid)
         ##1 (i_ce && rd_take && i_rd_seq && i_rd_addr == asor_pkg::ADDR_X_LO)
         |=> (o_rd_data == {$past(words[0][5:0]), 2'h0});
   endproperty
   a_x_lo: assert property (p_x_lo) else $error("x low byte wrong");

   property p_en_clear;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && !i_en) |=> (words[0] == '0) && (words[1] == '0) && (words[2] == '0)
         && (o_axis_ready == '0) && !o_all_axes_ready_flag;
   endproperty
   a_en_clear: assert property (p_en_clear) else $error("enable low kept data");

   property p_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_sample_valid) |=> (words[0] == $past(words[0]));
   endproperty
   a_hold: assert property (p_hold) else $error("sample lost while enabled");

   property p_pad;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && hit_lo) |=> (o_rd_data[1:0] == asor_pkg::LO_PAD);
   endproperty
   a_pad: assert property (p_pad) else $error("low pad bits set");

   property p_y_hi;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_Y_HI)
         |=> (o_rd_data == $past(words[1][13:6]));
   endproperty
   a_y_hi: assert property (p_y_hi) else $error("y high byte wrong");

   property p_z_lo;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_Z_HI && !i_sample_valid)
         ##1 (i_ce && rd_take && i_rd_seq && i_rd_addr == asor_pkg::ADDR_Z_LO)
         |=> (o_rd_data == {$past(words[2][5:0]), 2'h0});
   endproperty
   a_z_lo: assert property (p_z_lo) else $error("z low byte wrong");

   property p_no_ack;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && !i_rd_req) |=> !o_rd_ack;
   endproperty
   a_no_ack: assert property (p_no_ack) else $error("ack without read");

   property p_idle_data;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && !i_rd_req) |=> (o_rd_data == asor_pkg::RESET_BYTE);
   endproperty
   a_idle_data: assert property (p_idle_data) else $error("idle data not zero");

   property p_out_range;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_rd_req && !in_range) |=> (o_rd_data == asor_pkg::RESET_BYTE);
   endproperty
   a_out_range: assert property (p_out_range) else $error("foreign address read");

   property p_en_read;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_rd_req && !i_en) |=> o_rd_ack && (o_rd_data == asor_pkg::RESET_BYTE);
   endproperty
   a_en_read: assert property (p_en_read) else $error("read while disabled");

   property p_lo_flags;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_sample_valid && hit_lo) |=> $stable(o_axis_ready);
   endproperty
   a_lo_flags: assert property (p_lo_flags) else $error("low read moved flag");

   property p_flag_set;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && i_sample_valid) |=> (o_axis_ready == asor_pkg::ALL_AXES);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("axis flags not set");

   property p_x_clr;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_sample_valid && i_rd_req && i_rd_addr == asor_pkg::ADDR_X_HI)
         |=> !o_axis_ready[0];
   endproperty
   a_x_clr: assert property (p_x_clr) else $error("x flag kept");

   property p_y_clr;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_sample_valid && i_rd_req && i_rd_addr == asor_pkg::ADDR_Y_HI)
         |=> !o_axis_ready[1];
   endproperty
   a_y_clr: assert property (p_y_clr) else $error("y flag kept");

   property p_z_clr;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_sample_valid && i_rd_req && i_rd_addr == asor_pkg::ADDR_Z_HI)
         |=> !o_axis_ready[2];
   endproperty
   a_z_clr: assert property (p_z_clr) else $error("z flag kept");

   property p_flag_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && !i_rd_req && !i_sample_valid)
         |=> $stable(o_axis_ready) && $stable(o_all_axes_ready_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag moved while idle");

   property p_freeze;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_ce |=> $stable(o_rd_data) && $stable(o_rd_ack) && $stable(o_axis_ready)
         && $stable(o_all_axes_ready_flag);
   endproperty
   a_freeze: assert property (p_freeze) else $error("output moved while frozen");

   property p_freeze_words;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_ce |=> $stable(words[0]) && $stable(words[1]) && $stable(words[2]);
   endproperty
   a_freeze_words: assert property (p_freeze_words) else $error("sample moved frozen");

   property p_load_words;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en && i_sample_valid) |=> (words[0] == $past(i_x_sample_bits))
         && (words[1] == $past(i_y_sample_bits)) && (words[2] == $past(i_z_sample_bits));
   endproperty
   a_load_words: assert property (p_load_words) else $error("sample not stored");

   property p_pos_max;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_X_HI && words[0] == asor_pkg::SAMPLE_POS_MAX)
         |=> (o_rd_data == 8'h7F);
   endproperty
   a_pos_max: assert property (p_pos_max) else $error("positive maximum wrong");

   property p_neg_max;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_Y_HI && words[1] == asor_pkg::SAMPLE_NEG_MAX)
         |=> (o_rd_data == 8'h80);
   endproperty
   a_neg_max: assert property (p_neg_max) else $error("negative maximum wrong");

   property p_minus_one;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && rd_take && i_rd_addr == asor_pkg::ADDR_Z_HI && words[2] == '1)
         |=> (o_rd_data == 8'hFF);
   endproperty
   a_minus_one: assert property (p_minus_one) else $error("minus one count wrong");

   c_pair_new_sample: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && hit_hi) ##1 (i_ce && hit_lo && lo_ok && i_sample_valid));
   c_all_clear: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_all_axes_ready_flag ##1 !o_all_axes_ready_flag);
   c_neg_max: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      words[0] == asor_pkg::SAMPLE_NEG_MAX);
   c_en_drop: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_ce && i_en) ##1 (i_ce && !i_en));
   c_freeze: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_ce ##1 i_ce);
endmodule

// ==== asor_host_model.sv ====
// Host side model: issues register reads on the bank's read port
`timescale 1ns/10ps
module asor_host_model (
   // Clock
   input wire logic i_ref_clk,
   // Answer and status from the bank
   input wire logic [asor_pkg::DATA_W-1:0] i_rd_data,
   input wire logic i_rd_ack,
   input wire logic i_all_axes_ready_flag,
   // Read request
   output logic o_rd_req,
   output logic [asor_pkg::ADDR_W-1:0] o_rd_addr,
   output logic o_rd_seq
);
   logic [asor_pkg::DATA_W-1:0] got [0:7];
   int ack_miss = 0;

   initial begin
      o_rd_req = 1'b0;
      o_rd_addr = 8'h00;
      o_rd_seq = 1'b0;
   end

   // -----------------------------------------------------------------------
   // Burst read with auto-increment, 0x06 wraps to 0x00
   // -----------------------------------------------------------------------
   // Low bytes are reached as the step after their high byte, or as the first step when a burst starts on them
   task automatic burst(input logic [7:0] start, input int n);
      logic [7:0] a;
      a = start;
      @(posedge i_ref_clk);
      #1;
      for (int k = 0; k < n; k++) begin
         o_rd_req = 1'b1;
         o_rd_addr = a;
         o_rd_seq = (k != 0);
         @(posedge i_ref_clk);
         #1;
         got[k] = i_rd_data;
         if (i_rd_ack !== 1'b1) begin
            ack_miss++;
         end
         a = (a == 8'h06) ? 8'h00 : a + 8'h01;
      end
      // Address no longer qualified: show a changed value, not the old one
      o_rd_req = 1'b0;
      o_rd_addr = ~o_rd_addr;
      o_rd_seq = 1'b0;
   endtask

   // Waits up to 8 cycles for all three axes to report new data; ok tells whether they did
   task automatic wait_ready(output logic ok);
      ok = 1'b0;
      for (int k = 0; k < 8 && !ok; k++) begin
         if (i_all_axes_ready_flag === 1'b1) begin
            ok = 1'b1;
         end else begin
            @(posedge i_ref_clk);
            #1;
         end
      end
   endtask
endmodule

// ==== asor_regs_tb_top.sv ====
// Self-checking testbench of the axis sample output register bank
`timescale 1ns/10ps
module asor_regs_tb_top;
   logic i_ref_clk, i_rst_n, i_ce, i_en, i_sample_valid, i_rd_req, i_rd_seq, o_rd_ack;
   logic [13:0] i_x_sample_bits, i_y_sample_bits, i_z_sample_bits;
   logic [7:0] i_rd_addr, o_rd_data;
   logic [2:0] o_axis_ready;
   logic o_all_axes_ready_flag, ok;
   int errors = 0;
   int num_checks = 0;
   logic [13:0] codes [0:3] = '{14'h1FFF, 14'h2000, 14'h3FFF, 14'h0000};

   asor_regs dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_en(i_en),
      .i_sample_valid(i_sample_valid), .i_x_sample_bits(i_x_sample_bits),
      .i_y_sample_bits(i_y_sample_bits), .i_z_sample_bits(i_z_sample_bits),
      .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr), .i_rd_seq(i_rd_seq),
      .o_rd_data(o_rd_data), .o_rd_ack(o_rd_ack), .o_axis_ready(o_axis_ready),
      .o_all_axes_ready_flag(o_all_axes_ready_flag));
   asor_host_model host_u (.i_ref_clk(i_ref_clk), .i_rd_data(o_rd_data), .i_rd_ack(o_rd_ack),
      .i_all_axes_ready_flag(o_all_axes_ready_flag), .o_rd_req(i_rd_req),
      .o_rd_addr(i_rd_addr), .o_rd_seq(i_rd_seq));

   // -----------------------------------------------------------------------
   // Shared helpers
   // -----------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] exp_byte(input logic [13:0] s, input bit hi);
      exp_byte = hi ? s[13:6] : {s[5:0], 2'b00};
   endfunction

   task automatic load(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
      @(posedge i_ref_clk);
      #1;
      i_sample_valid = 1'b1;
      {i_x_sample_bits, i_y_sample_bits, i_z_sample_bits} = {x, y, z};
      @(posedge i_ref_clk);
      #1;
      i_sample_valid = 1'b0;
   endtask

   // Full burst of all six bytes against expected samples, then flags cleared
   task automatic read_all(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
      logic [13:0] s [0:2];
      s = '{x, y, z};
      host_u.burst(8'h01, 6);
      for (int k = 0; k < 6; k++) begin
         chk(host_u.got[k], exp_byte(s[k/2], (k % 2) == 0));
      end
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'h0);
   endtask

   // -----------------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------------
   task automatic t_reset;
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'h0);
      read_all(14'h0000, 14'h0000, 14'h0000);
      $display("test reset values done");
   endtask

   // Extreme, minus-one and zero codes rotated through all axes
   task automatic t_codes;
      for (int i = 0; i < 4; i++) begin
         load(codes[i], codes[(i+1)%4], codes[(i+2)%4]);
         chk({o_axis_ready, o_all_axes_ready_flag}, 4'hF);
         host_u.wait_ready(ok);
         chk(ok, 1'b1);
         read_all(codes[i], codes[(i+1)%4], codes[(i+2)%4]);
      end
      $display("test code table done");
   endtask

   // Per-axis flags clear one by one; stray low-byte reads answer zero
   task automatic t_flags_random;
      load(14'h1234, 14'h0ABC, 14'h3456);
      host_u.burst(8'h02, 1);
      chk(host_u.got[0], 8'h00);
      host_u.burst(8'h01, 1);
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'hD);
      host_u.burst(8'h04, 1);
      chk(host_u.got[0], 8'h00);
      host_u.burst(8'h03, 1);
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'h9);
      host_u.burst(8'h05, 1);
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'h0);
      host_u.burst(8'h00, 1);
      chk(host_u.got[0], 8'h00);
      $display("test flags and random access done");
   endtask

   // New samples land with the high and with the low read: pair stays coherent
   task automatic t_lock;
      load(14'h2A5B, 14'h1111, 14'h2222);
      fork
         host_u.burst(8'h01, 2);
         begin
            @(posedge i_ref_clk);
            #1;
            i_sample_valid = 1'b1;
            {i_x_sample_bits, i_y_sample_bits, i_z_sample_bits} = {3{14'h15A4}};
            repeat (2) @(posedge i_ref_clk);
            #1;
            i_sample_valid = 1'b0;
         end
      join
      chk(host_u.got[0], exp_byte(14'h2A5B, 1'b1));
      chk(host_u.got[1], exp_byte(14'h2A5B, 1'b0));
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'hF);
      read_all(14'h15A4, 14'h15A4, 14'h15A4);
      $display("test coherent pair done");
   endtask

   // Enable low clears everything; a sample offered meanwhile is ignored
   task automatic t_enable;
      load(14'h3ABC, 14'h0123, 14'h2FED);
      repeat (3) @(posedge i_ref_clk);
      host_u.burst(8'h05, 1);
      chk(host_u.got[0], exp_byte(14'h2FED, 1'b1));
      i_en = 1'b0;
      load(14'h1FFF, 14'h1FFF, 14'h1FFF);
      host_u.burst(8'h01, 1);
      chk(host_u.got[0], 8'h00);
      i_en = 1'b1;
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'h0);
      read_all(14'h0000, 14'h0000, 14'h0000);
      $display("test enable clear done");
   endtask

   // Clock enable low freezes flags, read data and samples
   task automatic t_freeze;
      load(14'h0155, 14'h2AAA, 14'h1234);
      host_u.burst(8'h01, 1);
      i_ce = 1'b0;
      load(14'h3FFF, 14'h3FFF, 14'h3FFF);
      chk({o_axis_ready, o_all_axes_ready_flag}, 4'hD);
      chk(o_rd_data, exp_byte(14'h0155, 1'b1));
      i_ce = 1'b1;
      read_all(14'h0155, 14'h2AAA, 14'h1234);
      $display("test clock enable freeze done");
   endtask

   // -----------------------------------------------------------------------
   // Run control
   // -----------------------------------------------------------------------
   task automatic summarize;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   // Whole run is about a hundred cycles; allow a wide margin
   initial begin
      #100us;
      errors++;
      summarize();
   end

   initial begin
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      i_en = 1'b1;
      i_sample_valid = 1'b0;
      {i_x_sample_bits, i_y_sample_bits, i_z_sample_bits} = '0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      i_rst_n = 1'b1;
      t_reset();
      t_codes();
      t_flags_random();
      t_lock();
      t_enable();
      t_freeze();
      chk(16'(host_u.ack_miss), 16'h0000);
      summarize();
   end
endmodule
